// ==== sim/bus_far_side.sv ====
// Far-side model of the bus: an address pattern source that answers reads and supplies acknowledge vectors.
`timescale 1ns/1ps
module bus_far_side (
	// Clock.
	input wire logic clk,
	// Pins watched on the bus.
	input wire logic [31:0] addressLines,
	input wire logic lowStrobeB,
	input wire logic upStrobeB,
	input wire logic readDir,
	input wire logic dataOe,
	// Value the far side puts on the data wire.
	output logic [15:0] farData
);
	logic [15:0] lastQ = 16'h0; // Last value seen on the far-side drivers.
	// Answer a read with a pattern of the address; a vector lands on the low byte.
	always_comb begin
		if (readDir && !dataOe && !(lowStrobeB && upStrobeB)) begin
			farData = addressLines[15:0] ^ 16'hc3a5;
		end else begin
			// A released wire must not keep its last value, or a stale read could pass by luck.
			farData = ~lastQ;
		end
	end
	// Remember what was driven so the idle pattern changes every cycle.
	always_ff @(posedge clk) begin
		lastQ <= farData;
	end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the processor bus pin stage.
`timescale 1ns/1ps
`include "cpu_bus_pin_regs.svh"
`define CHK(w, e, g) begin \
	checkCount++; \
	if ((g) !== (e)) begin \
		nErrors++; \
		$display("Error %s expected %h seen %h", w, e, g); \
	end \
end
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0; // Clock and bench reset.
	logic cycleValid = 1'b0, cycleWrite = 1'b0, cycleIack = 1'b0;
	logic cycleByte = 1'b0, cycleRmw = 1'b0;
	logic [31:0] cycleAddr = 32'h0;
	logic [15:0] cycleWdata = 16'h0;
	logic [2:0] cycleIackLevel = 3'h0, cycleClass = 3'h0;
	logic eightBitMode = 1'b0, haltB = 1'b1, stopExecuted = 1'b0;
	logic busReleased = 1'b0, resetInB = 1'b1;
	logic [15:0] readData, dataOut, farData, dataLinesIn;
	logic [31:0] addrPins;
	logic addrOe, dataOe, ctrlOe, clockEcho;
	logic addrStrobeB, upStrobeB, lowStrobeB, anyStrobeB, dirRead, earlyDirB, rmwFlagB;
	logic [2:0] classPins;
	logic [1:0] widthPins;
	logic [3:0] causeTab [4] = '{4'h1, 4'hd, 4'hb, 4'h8}; // Halt, stop, release, reset input.
	int nErrors = 0, checkCount = 0;
	// A steady square wave; the design must not reshape it.
	initial begin
		forever #20 clk = ~clk;
	end
	// The wire level: the design wins while it drives, else the far side.
	assign dataLinesIn = dataOe ? dataOut : farData;
	cpu_bus_pin_interface dut (.clk(clk), .rst_b(rst_b), .cycleValid(cycleValid),
		.cycleWrite(cycleWrite), .cycleIack(cycleIack), .cycleByte(cycleByte), .cycleRmw(cycleRmw),
		.cycleAddr(cycleAddr), .cycleWdata(cycleWdata), .cycleIackLevel(cycleIackLevel),
		.cycleClass(cycleClass), .eightBitMode(eightBitMode), .halt_request_input_b(haltB),
		.stopExecuted(stopExecuted), .busReleased(busReleased), .reset_input_b(resetInB),
		.readData_q(readData), .address_lines_q(addrPins), .addrOe_q(addrOe),
		.dataLinesIn(dataLinesIn), .data_lines_q(dataOut), .dataOe_q(dataOe),
		.address_valid_strobe_b_q(addrStrobeB), .upper_byte_strobe_b_q(upStrobeB),
		.lower_byte_strobe_b_q(lowStrobeB), .any_byte_strobe_b_q(anyStrobeB),
		.transfer_direction_q(dirRead), .early_transfer_direction_b_q(earlyDirB),
		.indivisible_cycle_flag_b_q(rmwFlagB), .cycle_class_code_q(classPins),
		.transfer_width_code_q(widthPins), .ctrlOe_q(ctrlOe), .clock_input(clk),
		.clock_echo_output(clockEcho));
	bus_far_side far (.clk(clk), .addressLines(addrPins), .lowStrobeB(lowStrobeB),
		.upStrobeB(upStrobeB), .readDir(dirRead), .dataOe(dataOe), .farData(farData));
	// Prints the counts and the verdict, then stops the run.
	task automatic finalReport;
		$display("Checks %0d, mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// One cycle of a kind: 0 word write, 1 byte write, 2 word read, 3 acknowledge, 4/5 8-bit w/r.
	task automatic runCycle(input int kind);
		logic [31:0] a, ea;
		logic [15:0] w, rd;
		logic [3:0] cr;
		logic [2:0] lvl;
		logic eight, wr, ack, bt;
		a = $urandom;
		w = 16'($urandom);
		cr = 4'($urandom);
		lvl = 3'($urandom);
		eight = kind >= 4;
		wr = kind inside {0, 1, 4};
		ack = kind == 3;
		bt = kind == 1 || eight;
		@(posedge clk);
		{eightBitMode, cycleValid, cycleWrite, cycleIack, cycleByte} <= {eight, 1'b1, wr, ack, bt};
		{cycleAddr, cycleWdata, cycleIackLevel, cycleClass, cycleRmw} <= {a, w, lvl, cr};
		// Three edges let a read answer settle before the captured value is judged.
		repeat (3) @(posedge clk);
		#1;
		ea = ack ? {28'hfffffff, lvl, 1'b1} : a;
		rd = ea[15:0] ^ 16'hc3a5;
		`CHK("address", ea, addrPins)
		`CHK("direction", ~wr, dirRead)
		`CHK("early direction", ~wr, earlyDirB)
		`CHK("address strobe", 1'b0, addrStrobeB)
		`CHK("class code", cr[3:1], classPins)
		`CHK("rmw flag", ~cr[0], rmwFlagB)
		`CHK("data drive", wr, dataOe)
		`CHK("clock echo", clk, clockEcho)
		if (!ack) begin
			`CHK("upper strobe", kind == 1 ? a[0] : eight, upStrobeB)
			`CHK("lower strobe", kind == 1 ? ~a[0] : 1'b0, lowStrobeB)
			`CHK("width", bt ? `SIZE_BYTE : `SIZE_WORD, widthPins)
		end
		if (wr) begin
			`CHK("write low byte", w[7:0], dataOut[7:0])
			if (!eight) `CHK("write data", kind == 0 ? w : {w[7:0], w[7:0]}, dataOut)
		end else begin
			`CHK("read data", (eight || ack) ? {8'h00, rd[7:0]} : rd, readData)
		end
		// The request is dropped on a rising edge, as every other input change is.
		@(posedge clk);
		cycleValid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`CHK("idle strobe", 1'b1, anyStrobeB)
		`CHK("idle data drive", 1'b0, dataOe)
	endtask
	// Holds a write while one floating cause is applied, then checks which drivers let go.
	task automatic floatCase(input int c);
		@(posedge clk);
		{cycleValid, cycleWrite, cycleIack, cycleByte, eightBitMode} <= 5'h18;
		{haltB, stopExecuted, busReleased, resetInB} <= causeTab[c];
		repeat (3) @(posedge clk);
		#21;
		`CHK("data float", 1'b0, dataOe)
		`CHK("address drive", c < 2, addrOe)
		`CHK("control drive", c < 2, ctrlOe)
		`CHK("clock echo low", clk, clockEcho)
		@(posedge clk);
		{haltB, stopExecuted, busReleased, resetInB, cycleValid} <= 5'h12;
		repeat (2) @(posedge clk);
	endtask
	// Main sequence: reset, random cycles of every kind, then every floating cause.
	initial begin
		void'($urandom(67611));
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 60; i++) begin
			runCycle(i % 6);
		end
		$display("Test bus cycles done");
		for (int c = 0; c < 4; c++) begin
			floatCase(c);
		end
		$display("Test floating done");
		finalReport;
	end
	// Watchdog: the tests need about 460 cycles, so 2500 means a hang.
	initial begin
		#100000;
		nErrors++;
		finalReport;
	end
endmodule

// ==== src/clock_echo.sv ====
// Clock echo stage that mirrors the clock input onto the clock echo output.
`timescale 1ns/1ps
module clock_echo (
	// Clock in.
	input wire logic clock_input,
	// Clock echo out.
	output wire logic clock_echo_output
);
	// The echo is a plain buffer so that it follows the input with no shaping.
	assign clock_echo_output = clock_input;
endmodule

// ==== src/cpu_bus_pin_interface.sv ====
// Pin stage of the processor external bus: address, data, strobes, floating.
`timescale 1ns/1ps
`include "cpu_bus_pin_regs.svh"
module cpu_bus_pin_interface (
	// Clock and synchronous active-low reset.
	input wire logic clk,
	input wire logic rst_b,
	// Core-side cycle request, held while cycleValid is high.
	input wire logic cycleValid,
	input wire logic cycleWrite,
	input wire logic cycleIack,
	input wire logic cycleByte,
	input wire logic cycleRmw,
	input wire logic [`ADDR_WIDTH-1:0] cycleAddr,
	input wire logic [`DATA_WIDTH-1:0] cycleWdata,
	input wire logic [2:0] cycleIackLevel,
	input wire logic [`CLASS_WIDTH-1:0] cycleClass,
	// Core-side modes and floating causes.
	input wire logic eightBitMode,
	input wire logic halt_request_input_b,
	input wire logic stopExecuted,
	input wire logic busReleased,
	input wire logic reset_input_b,
	// Core-side read return.
	output logic [`DATA_WIDTH-1:0] readData_q,
	// Address pins.
	output logic [`ADDR_WIDTH-1:0] address_lines_q,
	output logic addrOe_q,
	// Data pins, split into in, out and enable.
	input wire logic [`DATA_WIDTH-1:0] dataLinesIn,
	output logic [`DATA_WIDTH-1:0] data_lines_q,
	output logic dataOe_q,
	// Control pins, active low except the direction (high for read), the class and width codes and the enable.
	output logic address_valid_strobe_b_q,
	output logic upper_byte_strobe_b_q,
	output logic lower_byte_strobe_b_q,
	output logic any_byte_strobe_b_q,
	output logic transfer_direction_q,
	output logic early_transfer_direction_b_q,
	output logic indivisible_cycle_flag_b_q,
	output logic [`CLASS_WIDTH-1:0] cycle_class_code_q,
	output logic [1:0] transfer_width_code_q,
	output logic ctrlOe_q,
	// Standard output that never floats.
	input wire logic clock_input,
	output wire logic clock_echo_output
);
	// Decoded cycle kind, used to steer the pin values.
	cpu_bus_pin_pkg::cycle_t cycleKind;
	// True while reset input or bus release forces every three-state pin to float.
	logic floatAll;
	// True while halt or stop leaves only the data lines floating.
	logic floatData;
	// Next data pin value and byte lane choice.
	logic [`DATA_WIDTH-1:0] wdata_d;
	logic upperLane;

	// Reset input is asserted when low; assertion follows the pin's active level.
	assign floatAll = busReleased | ~reset_input_b;
	assign floatData = ~halt_request_input_b | stopExecuted;
	assign upperLane = ~cycleAddr[0];

	// Classify the request so each pin process sees one state.
	always_comb begin
		if (!cycleValid) begin
			cycleKind = cpu_bus_pin_pkg::CYC_IDLE;
		end else if (cycleIack) begin
			cycleKind = cpu_bus_pin_pkg::CYC_IACK;
		end else if (cycleWrite) begin
			cycleKind = cpu_bus_pin_pkg::CYC_WRITE;
		end else begin
			cycleKind = cpu_bus_pin_pkg::CYC_READ;
		end
	end

	// Write data lane placement; bytes are copied so either lane carries them.
	always_comb begin
		if (cycleByte || eightBitMode) begin
			// The byte sits in the low half of the request and fills both halves.
			// In 8-bit mode the upper half is driven too but carries no meaning.
			wdata_d = {cycleWdata[7:0], cycleWdata[7:0]};
		end else begin
			wdata_d = cycleWdata;
		end
	end

	// Address pins: cycle address, or the level with all other bits high on acknowledge.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			address_lines_q <= `ACK_ADDR_FILL;
		end else if (cycleKind == cpu_bus_pin_pkg::CYC_IACK) begin
			address_lines_q <= `ACK_ADDR_FILL;
			address_lines_q[`ACK_LEVEL_MSB:`ACK_LEVEL_LSB] <= cycleIackLevel;
		end else if (cycleValid) begin
			address_lines_q <= cycleAddr;
		end
	end

	// Address enable drops only on release or reset, never on halt.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addrOe_q <= 1'b0;
			ctrlOe_q <= 1'b0;
		end else begin
			addrOe_q <= ~floatAll;
			ctrlOe_q <= ~floatAll;
		end
	end

	// Data pins: driven on writes unless any floating cause is present.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			data_lines_q <= 16'h0000;
			dataOe_q <= 1'b0;
		end else begin
			data_lines_q <= wdata_d;
			// Only the data lines float for halt or stop.
			dataOe_q <= (cycleKind == cpu_bus_pin_pkg::CYC_WRITE) & ~floatAll & ~floatData;
		end
	end

	// Strobes and direction; a byte uses the lane chosen by address bit 0, except in 8-bit mode, which always uses the lower lane.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			address_valid_strobe_b_q <= 1'b1;
			upper_byte_strobe_b_q <= 1'b1;
			lower_byte_strobe_b_q <= 1'b1;
			any_byte_strobe_b_q <= 1'b1;
			transfer_direction_q <= 1'b1;
			early_transfer_direction_b_q <= 1'b1;
			indivisible_cycle_flag_b_q <= 1'b1;
		end else begin
			address_valid_strobe_b_q <= ~cycleValid;
			// 8-bit mode holds the upper strobe negated for every cycle.
			upper_byte_strobe_b_q <= ~(cycleValid & ~eightBitMode & (~cycleByte | upperLane));
			lower_byte_strobe_b_q <= ~(cycleValid & (eightBitMode | ~cycleByte | ~upperLane));
			any_byte_strobe_b_q <= ~cycleValid;
			transfer_direction_q <= ~(cycleKind == cpu_bus_pin_pkg::CYC_WRITE);
			early_transfer_direction_b_q <= ~(cycleKind == cpu_bus_pin_pkg::CYC_WRITE);
			indivisible_cycle_flag_b_q <= ~(cycleValid & cycleRmw);
		end
	end

	// Class and width codes follow the request.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cycle_class_code_q <= 3'h0;
			transfer_width_code_q <= `SIZE_WORD;
		end else if (cycleValid) begin
			cycle_class_code_q <= cycleClass;
			transfer_width_code_q <= (cycleByte | eightBitMode) ? `SIZE_BYTE : `SIZE_WORD;
		end
	end

	// Read capture; the vector of an acknowledge arrives on the low byte.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			readData_q <= 16'h0000;
		end else if (cycleKind == cpu_bus_pin_pkg::CYC_IACK) begin
			readData_q <= {8'h00, dataLinesIn[7:0]};
		end else if (cycleKind == cpu_bus_pin_pkg::CYC_READ) begin
			// In 8-bit mode the upper byte is discarded, whatever it carries.
			readData_q <= eightBitMode ? {8'h00, dataLinesIn[7:0]} : dataLinesIn;
		end
	end

	// The clock echo never floats; the input is assumed clean and steady.
	clock_echo uEcho (
		.clock_input(clock_input),
		.clock_echo_output(clock_echo_output)
	);

	// Checks on the pin stage.
	property p_iackAddr;
		@(posedge clk) disable iff (!rst_b)
		(cycleKind == cpu_bus_pin_pkg::CYC_IACK) |=>
		address_lines_q == {28'hfffffff, $past(cycleIackLevel), 1'b1};
	endproperty
	a_iackAddr: assert property (p_iackAddr) else $error("Acknowledge address wrong.");
	property p_cycAddr;
		@(posedge clk) disable iff (!rst_b)
		(cycleValid && !cycleIack) |=> address_lines_q == $past(cycleAddr);
	endproperty
	a_cycAddr: assert property (p_cycAddr) else $error("Cycle address wrong.");
	property p_upperNeg;
		@(posedge clk) disable iff (!rst_b)
		eightBitMode |=> upper_byte_strobe_b_q;
	endproperty
	a_upperNeg: assert property (p_upperNeg) else $error("Upper strobe asserted in 8-bit.");
	property p_haltData;
		@(posedge clk) disable iff (!rst_b)
		(floatData && !floatAll) |=> !dataOe_q && addrOe_q && ctrlOe_q;
	endproperty
	a_haltData: assert property (p_haltData) else $error("Halt floating wrong.");
	property p_floatAll;
		@(posedge clk) disable iff (!rst_b)
		floatAll |=> !dataOe_q && !addrOe_q && !ctrlOe_q;
	endproperty
	a_floatAll: assert property (p_floatAll) else $error("Release floating wrong.");
	property p_byteCopy;
		@(posedge clk) disable iff (!rst_b)
		(cycleKind == cpu_bus_pin_pkg::CYC_WRITE && cycleByte) |=>
		data_lines_q[15:8] == data_lines_q[7:0];
	endproperty
	a_byteCopy: assert property (p_byteCopy) else $error("Byte not copied.");
	property p_eightRead;
		@(posedge clk) disable iff (!rst_b)
		(cycleKind == cpu_bus_pin_pkg::CYC_READ && eightBitMode) |=> readData_q[15:8] == 8'h00;
	endproperty
	a_eightRead: assert property (p_eightRead) else $error("Upper byte not ignored.");
	property p_eightWrite;
		@(posedge clk) disable iff (!rst_b)
		(cycleKind == cpu_bus_pin_pkg::CYC_WRITE && eightBitMode && !floatAll && !floatData)
		|=> dataOe_q && data_lines_q[7:0] == $past(cycleWdata[7:0]);
	endproperty
	a_eightWrite: assert property (p_eightWrite) else $error("8-bit write wrong.");
	property p_wordWrite;
		@(posedge clk) disable iff (!rst_b)
		(cycleKind == cpu_bus_pin_pkg::CYC_WRITE && !cycleByte && !eightBitMode)
		|=> data_lines_q == $past(cycleWdata);
	endproperty
	a_wordWrite: assert property (p_wordWrite) else $error("Word write wrong.");
endmodule

// ==== src/cpu_bus_pin_pkg.sv ====
// Types for the processor external bus pin stage.
package cpu_bus_pin_pkg;
	// Kind of bus cycle requested by the core.
	typedef enum logic [3:0] {
		CYC_IDLE = 4'h1,
		CYC_READ = 4'h2,
		CYC_WRITE = 4'h4,
		CYC_IACK = 4'h8
	} cycle_t;
endpackage

// ==== src/cpu_bus_pin_regs.svh ====
// Constants for the processor external bus pin stage.
`ifndef CPU_BUS_PIN_REGS_SVH
`define CPU_BUS_PIN_REGS_SVH
`define ADDR_WIDTH 32
`define DATA_WIDTH 16
`define ACK_LEVEL_LSB 1
`define ACK_LEVEL_MSB 3
`define ACK_ADDR_FILL 32'hffffffff
`define CLASS_WIDTH 3
`define SIZE_BYTE 2'h2
`define SIZE_WORD 2'h1
`endif
